// *** rtl/cdic_pkg.sv ***
/*
 Constants and carrier types for the cascaded dual interrupt controller.
 Assumes one 50 MHz clock domain shared with the CPU I/O strobes.
*/
// Operation
// - Two chained controllers at 20h/21h, A0h/A1h
// - Slave interrupt output feeds master input 2
// - Level sensing only, edge select ignored
// - Per-level masks; 70h bit 7 masks NMI
// - Auxiliary input ORed onto level 12
// - Serial one counted only while gate low
// - Serial one: alternate level 3, primary 4
// - Serial two counted only while gate low
// - Serial two: primary level 4, alternate 3
// - Shared levels OR all their sources
// - Pending bit follows active request level
// - Acknowledge sets highest unmasked pending in-service bit
// - Masking one line leaves others serviced
// - Command writes taken, status read back
// - Stored command words steer operating modes
// - Slave acknowledge drives cascade identity 2
// - First acknowledge undriven, second drives vector
// - Default fixed priority, input 0 highest
// - End-of-interrupt command clears in-service bit
package cdic_pkg;
   // Port addresses
   localparam logic [15:0] MASTER_EVEN_ADDR = 16'h0020;
   localparam logic [15:0] MASTER_ODD_ADDR = 16'h0021;
   localparam logic [15:0] SLAVE_EVEN_ADDR = 16'h00A0;
   localparam logic [15:0] SLAVE_ODD_ADDR = 16'h00A1;
   localparam logic [15:0] NMI_MASK_ADDR = 16'h0070;
   localparam int NMI_MASK_BIT = 7;
   // Levels
   localparam logic [2:0] CASCADE_LEVEL = 3'h2;
   localparam logic [2:0] SPURIOUS_LEVEL = 3'h7;
   localparam logic [2:0] LOW_RESET = 3'h7;
   localparam int AUX_LEVEL = 12;
   localparam int ALT_LEVEL = 3;
   localparam int PRI_LEVEL = 4;
   // Synchroniser bit positions
   localparam int SYNC_W = 22;
   localparam int SY_AUX = 16;
   localparam int SY_SER1 = 17;
   localparam int SY_SER2 = 18;
   localparam int SY_GATE1 = 19;
   localparam int SY_GATE2 = 20;
   localparam int SY_NMI = 21;
   // Command word fields
   localparam int INIT_SEL_BIT = 4;
   localparam int INIT_MODE_BIT = 0;
   localparam int INIT_SINGLE_BIT = 1;
   localparam int MODE_AEOI_BIT = 1;
   localparam int MODE_SFNM_BIT = 4;
   localparam int OPS_SEL_BIT = 3;
   localparam int OPS_POLL_BIT = 2;
   localparam int OPS_RR_BIT = 1;
   localparam int OPS_RIS_BIT = 0;
   localparam int OPS_ESMM_BIT = 6;
   localparam int OPS_SMM_BIT = 5;
   // Operation command word 2 codes
   localparam logic [2:0] EOI_NONSPEC = 3'h1;
   localparam logic [2:0] EOI_SPEC = 3'h3;
   localparam logic [2:0] EOI_ROT_NONSPEC = 3'h5;
   localparam logic [2:0] EOI_ROT_SPEC = 3'h7;
   localparam logic [2:0] SET_PRIO = 3'h6;
   localparam logic [2:0] ROT_AEOI_SET = 3'h4;
   localparam logic [2:0] ROT_AEOI_CLR = 3'h0;
   // Controller index
   localparam int MST = 0;
   localparam int SLV = 1;

   // Initialisation sequence
   typedef enum logic [1:0] {CDIC_READY, CDIC_WAIT_VEC, CDIC_WAIT_CAS, CDIC_WAIT_MODE}
      cdic_init_type;

   // CPU I/O access
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cdic_io_type;

   // One controller
   typedef struct packed {
      logic [7:0] pend;
      logic [7:0] insvc;
      logic [7:0] mask;
      logic [4:0] vec;
      cdic_init_type step;
      logic want_mode;
      logic single;
      logic aeoi;
      logic sfnm;
      logic ris;
      logic poll;
      logic smm;
      logic rot_aeoi;
      logic [2:0] low;
   } cdic_ctl_type;

   // Whole block state
   typedef struct packed {
      cdic_ctl_type [1:0] ctl;
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [1:0] age;
      logic nmi_mask;
      logic nmi_out;
      logic ack_second;
      logic [3:0] ack_lvl;
      logic [7:0] hold;
      logic [2:0] cas;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] vec_out;
      logic vec_oe;
   } cdic_state_type;
endpackage

// *** rtl/cdic_top.sv ***
/*
 Two cascaded 8-level interrupt controllers with peripheral request routing.
 Assumes CPU I/O strobes and serial setup levels on clk; request pins are asynchronous.
*/
`timescale 1ns/1ns
module cdic_top (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // CPU I/O port access
   input wire cdic_pkg::cdic_io_type io_req,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   // Acknowledge and request to CPU
   input wire logic interrupt_ack_cycle,
   output logic cpu_interrupt_request,
   output logic [7:0] ack_vector,
   output logic ack_vector_oe,
   output logic [2:0] cascade_id,
   // Request pins
   input wire logic [15:0] channel_irq,
   input wire logic auxiliary_irq_input,
   input wire logic serial_one_irq_input,
   input wire logic serial_one_irq_gate_n,
   input wire logic serial_two_irq_input,
   input wire logic serial_two_irq_gate_n,
   // Serial port setup
   input wire logic serial_one_enable,
   input wire logic serial_one_alternate,
   input wire logic serial_two_enable,
   input wire logic serial_two_alternate,
   // Non-maskable interrupt
   input wire logic nmi_request,
   output logic nmi_to_cpu
);
   cdic_pkg::cdic_state_type q; // Registered state
   cdic_pkg::cdic_state_type d; // Next state
   logic [15:0] lv; // Combined request levels
   logic s1_hit; // Gated serial one request
   logic s2_hit; // Gated serial two request
   logic slave_int; // Slave request to master
   logic master_int; // Master request to CPU
   logic [3:0] m_pick; // Master winner, found flag on top
   logic [3:0] s_pick; // Slave winner
   logic [3:0] p_pick; // Poll winner
   logic ctl_hit; // Access hits a controller port
   logic sel; // Which controller
   cdic_pkg::cdic_ctl_type c_rd; // Controller being read

   // Most urgent set bit, searching from the level after the lowest one
   function automatic logic [3:0] pick(input logic [7:0] b, input logic [2:0] low);
      logic [3:0] r;
      logic [2:0] k;
      r = 4'h0;
      for (int i = 8; i >= 1; i--) begin
         k = low + 3'(i);
         if (b[k]) begin
            r = {1'b1, k};
         end
      end
      return r;
   endfunction

   // Rank of a level, zero is most urgent
   function automatic logic [2:0] rank(input logic [2:0] k, input logic [2:0] low);
      return k - low - 3'h1;
   endfunction

   // Levels that an acknowledge may take
   function automatic logic [7:0] elig(input cdic_pkg::cdic_ctl_type c);
      return c.pend & ~c.mask & (c.smm ? ~c.insvc : 8'hFF);
   endfunction

   // Request out of one controller
   function automatic logic ctl_int(input cdic_pkg::cdic_ctl_type c);
      logic [3:0] p;
      logic [3:0] b;
      logic [7:0] blk;
      // Nested slave levels must not lock each other out in SFNM
      blk = c.smm ? 8'h00 : (c.insvc & ~(c.sfnm ? 8'h04 : 8'h00));
      p = pick(elig(c), c.low);
      b = pick(blk, c.low);
      return p[3] && (!b[3] || (rank(p[2:0], c.low) < rank(b[2:0], c.low)));
   endfunction

   // Command write on even or odd port
   function automatic cdic_pkg::cdic_ctl_type ctl_write(input cdic_pkg::cdic_ctl_type c,
         input logic odd, input logic [7:0] v);
      cdic_pkg::cdic_ctl_type r;
      logic [3:0] p;
      r = c;
      p = pick(c.smm ? (c.insvc & ~c.mask) : c.insvc, c.low);
      if (!odd && v[cdic_pkg::INIT_SEL_BIT]) begin
         // Start of initialisation; trigger select bit has no effect
         r.mask = 8'h00;
         r.insvc = 8'h00;
         r.low = cdic_pkg::LOW_RESET;
         r.smm = 1'b0;
         r.ris = 1'b0;
         r.poll = 1'b0;
         r.aeoi = 1'b0;
         r.sfnm = 1'b0;
         r.rot_aeoi = 1'b0;
         r.want_mode = v[cdic_pkg::INIT_MODE_BIT];
         r.single = v[cdic_pkg::INIT_SINGLE_BIT];
         r.step = cdic_pkg::CDIC_WAIT_VEC;
      end else if (!odd && v[cdic_pkg::OPS_SEL_BIT]) begin
         // Poll, read select and special mask
         r.poll = v[cdic_pkg::OPS_POLL_BIT];
         if (v[cdic_pkg::OPS_RR_BIT]) begin
            r.ris = v[cdic_pkg::OPS_RIS_BIT];
         end
         if (v[cdic_pkg::OPS_ESMM_BIT]) begin
            r.smm = v[cdic_pkg::OPS_SMM_BIT];
         end
      end else if (!odd) begin
         // End of interrupt and rotation
         case (v[7:5])
            cdic_pkg::EOI_NONSPEC: begin
               if (p[3]) begin
                  r.insvc[p[2:0]] = 1'b0;
               end
            end
            cdic_pkg::EOI_SPEC: begin
               r.insvc[v[2:0]] = 1'b0;
            end
            cdic_pkg::EOI_ROT_NONSPEC: begin
               if (p[3]) begin
                  r.insvc[p[2:0]] = 1'b0;
                  r.low = p[2:0];
               end
            end
            cdic_pkg::EOI_ROT_SPEC: begin
               r.insvc[v[2:0]] = 1'b0;
               r.low = v[2:0];
            end
            cdic_pkg::SET_PRIO: begin
               r.low = v[2:0];
            end
            cdic_pkg::ROT_AEOI_SET, cdic_pkg::ROT_AEOI_CLR: begin
               r.rot_aeoi = v[7];
            end
            default: begin
               r = r; // No operation code
            end
         endcase
      end else begin
         // Odd port: init words in turn, then the mask
         case (c.step)
            cdic_pkg::CDIC_WAIT_VEC: begin
               r.vec = v[7:3];
               if (c.single) begin
                  r.step = c.want_mode ? cdic_pkg::CDIC_WAIT_MODE : cdic_pkg::CDIC_READY;
               end else begin
                  r.step = cdic_pkg::CDIC_WAIT_CAS;
               end
            end
            cdic_pkg::CDIC_WAIT_CAS: begin
               // Cascade wiring is fixed, the word is only stepped over
               r.step = c.want_mode ? cdic_pkg::CDIC_WAIT_MODE : cdic_pkg::CDIC_READY;
            end
            cdic_pkg::CDIC_WAIT_MODE: begin
               r.aeoi = v[cdic_pkg::MODE_AEOI_BIT];
               r.sfnm = v[cdic_pkg::MODE_SFNM_BIT];
               r.step = cdic_pkg::CDIC_READY;
            end
            default: begin
               r.mask = v;
            end
         endcase
      end
      return r;
   endfunction

   // Next-state logic
   always_comb begin
      d = q;
      d.age = (q.age == 2'h3) ? q.age : q.age + 2'h1;
      // Pins pass two flops before use
      d.s1 = {nmi_request, serial_two_irq_gate_n, serial_one_irq_gate_n,
              serial_two_irq_input, serial_one_irq_input, auxiliary_irq_input, channel_irq};
      d.s2 = q.s1;
      // Source combining onto shared levels
      s1_hit = q.s2[cdic_pkg::SY_SER1] & ~q.s2[cdic_pkg::SY_GATE1] & serial_one_enable;
      s2_hit = q.s2[cdic_pkg::SY_SER2] & ~q.s2[cdic_pkg::SY_GATE2] & serial_two_enable;
      lv = q.s2[15:0];
      lv[cdic_pkg::AUX_LEVEL] = lv[cdic_pkg::AUX_LEVEL] | q.s2[cdic_pkg::SY_AUX];
      lv[cdic_pkg::ALT_LEVEL] = lv[cdic_pkg::ALT_LEVEL]
         | (s1_hit & serial_one_alternate)
         | (s2_hit & serial_two_alternate);
      lv[cdic_pkg::PRI_LEVEL] = lv[cdic_pkg::PRI_LEVEL]
         | (s1_hit & ~serial_one_alternate)
         | (s2_hit & ~serial_two_alternate);
      slave_int = ctl_int(q.ctl[cdic_pkg::SLV]);
      master_int = ctl_int(q.ctl[cdic_pkg::MST]);
      m_pick = pick(elig(q.ctl[cdic_pkg::MST]), q.ctl[cdic_pkg::MST].low);
      s_pick = pick(elig(q.ctl[cdic_pkg::SLV]), q.ctl[cdic_pkg::SLV].low);
      d.rvalid = 1'b0;
      d.vec_oe = 1'b0;
      d.nmi_out = q.s2[cdic_pkg::SY_NMI] & ~q.nmi_mask;
      // Port decode
      sel = io_req.addr[7];
      ctl_hit = (io_req.addr[15:1] == cdic_pkg::MASTER_EVEN_ADDR[15:1])
         || (io_req.addr[15:1] == cdic_pkg::SLAVE_EVEN_ADDR[15:1]);
      c_rd = q.ctl[sel];
      p_pick = pick(elig(c_rd), c_rd.low);
      if (io_req.wr && ctl_hit) begin
         d.ctl[sel] = ctl_write(q.ctl[sel], io_req.addr[0], io_req.wdata);
      end
      if (io_req.wr && (io_req.addr == cdic_pkg::NMI_MASK_ADDR)) begin
         d.nmi_mask = io_req.wdata[cdic_pkg::NMI_MASK_BIT];
      end
      // Status read, poll read acts as an acknowledge
      if (io_req.rd && ctl_hit) begin
         d.rvalid = 1'b1;
         if (!io_req.addr[0] && c_rd.poll) begin
            d.rdata = {p_pick[3], 4'h0, p_pick[2:0]};
            if (p_pick[3]) begin
               d.ctl[sel].insvc[p_pick[2:0]] = 1'b1;
            end
            d.ctl[sel].poll = 1'b0;
         end else if (io_req.addr[0]) begin
            d.rdata = c_rd.mask;
         end else begin
            d.rdata = c_rd.ris ? c_rd.insvc : c_rd.pend;
         end
      end
      // Acknowledge pair
      if (interrupt_ack_cycle && !q.ack_second) begin
         // First cycle: freeze winner, bus stays undriven
         d.ack_second = 1'b1;
         d.ack_lvl = m_pick;
         d.cas = 3'h0;
         if (!m_pick[3]) begin
            // Request vanished: spurious level 7 vector, nothing in service
            d.hold = {q.ctl[cdic_pkg::MST].vec, cdic_pkg::SPURIOUS_LEVEL};
         end else begin
            d.ctl[cdic_pkg::MST].insvc[m_pick[2:0]] = 1'b1;
            if (m_pick[2:0] == cdic_pkg::CASCADE_LEVEL && !q.ctl[cdic_pkg::MST].single) begin
               d.cas = cdic_pkg::CASCADE_LEVEL;
               if (s_pick[3]) begin
                  d.ctl[cdic_pkg::SLV].insvc[s_pick[2:0]] = 1'b1;
               end
               d.hold = {q.ctl[cdic_pkg::SLV].vec,
                         s_pick[3] ? s_pick[2:0] : cdic_pkg::SPURIOUS_LEVEL};
            end else begin
               d.hold = {q.ctl[cdic_pkg::MST].vec, m_pick[2:0]};
            end
         end
      end else if (interrupt_ack_cycle) begin
         // Second cycle: drive the vector
         d.ack_second = 1'b0;
         d.vec_out = q.hold;
         d.vec_oe = 1'b1;
         d.cas = 3'h0;
         if (q.ctl[cdic_pkg::MST].aeoi && q.ack_lvl[3]) begin
            d.ctl[cdic_pkg::MST].insvc[q.ack_lvl[2:0]] = 1'b0;
            if (q.ctl[cdic_pkg::MST].rot_aeoi) begin
               d.ctl[cdic_pkg::MST].low = q.ack_lvl[2:0];
            end
         end
      end
      // Pending bits track request levels
      d.ctl[cdic_pkg::SLV].pend = lv[15:8];
      d.ctl[cdic_pkg::MST].pend = {lv[7:3], slave_int, lv[1:0]};
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.ctl[cdic_pkg::MST].low <= cdic_pkg::LOW_RESET;
         q.ctl[cdic_pkg::SLV].low <= cdic_pkg::LOW_RESET;
      end else begin
         q <= d;
      end
   end

   // Outputs
   assign io_rdata = q.rdata;
   assign io_rdata_oe = q.rvalid;
   assign ack_vector = q.vec_out;
   assign ack_vector_oe = q.vec_oe;
   assign cascade_id = q.cas;
   assign cpu_interrupt_request = master_int;
   assign nmi_to_cpu = q.nmi_out;

   // Checks
   all_masked_a: assert property (@(posedge clk) disable iff (!resetn)
      (q.ctl[cdic_pkg::MST].mask == 8'hFF) |-> !cpu_interrupt_request)
      else $error("request with all master levels masked");
   nmi_mask_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(q.nmi_mask) |-> !nmi_to_cpu)
      else $error("nmi passed while masked");
   aux_level_a: assert property (@(posedge clk) disable iff (!resetn)
      (q.age == 2'h3) && $past(auxiliary_irq_input, 3) |-> q.ctl[cdic_pkg::SLV].pend[4])
      else $error("auxiliary request missing on level 12");
   ser1_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      (q.age == 2'h3) && $past(serial_one_irq_gate_n, 3) && !$past(channel_irq[3], 3)
      && !$past(channel_irq[4], 3) && !serial_two_enable && $past(!serial_two_enable)
      |-> !q.ctl[cdic_pkg::MST].pend[3] && !q.ctl[cdic_pkg::MST].pend[4])
      else $error("gated serial one request seen");
   cascade_in_a: assert property (@(posedge clk) disable iff (!resetn)
      (q.age == 2'h3) |-> q.ctl[cdic_pkg::MST].pend[2] == $past(slave_int))
      else $error("slave request not on master input 2");
   ack_first_a: assert property (@(posedge clk) disable iff (!resetn)
      interrupt_ack_cycle && !q.ack_second |=> !ack_vector_oe)
      else $error("vector driven in first acknowledge");
   ack_second_a: assert property (@(posedge clk) disable iff (!resetn)
      interrupt_ack_cycle && q.ack_second |=> ack_vector_oe ##1 !ack_vector_oe)
      else $error("vector not driven for one cycle");
   cascade_id_a: assert property (@(posedge clk) disable iff (!resetn)
      interrupt_ack_cycle && !q.ack_second && m_pick[3] && (m_pick[2:0] == 3'h2)
      && !q.ctl[cdic_pkg::MST].single |=> cascade_id == 3'h2)
      else $error("slave identity not driven");
   ack_isr_a: assert property (@(posedge clk) disable iff (!resetn)
      interrupt_ack_cycle && !q.ack_second && m_pick[3] && !io_req.wr
      |=> q.ctl[cdic_pkg::MST].insvc[$past(m_pick[2:0])])
      else $error("winner not placed in service");
   eoi_spec_a: assert property (@(posedge clk) disable iff (!resetn)
      io_req.wr && (io_req.addr == cdic_pkg::MASTER_EVEN_ADDR) && (io_req.wdata[7:3] == 5'h0C)
      && !interrupt_ack_cycle |=> !q.ctl[cdic_pkg::MST].insvc[$past(io_req.wdata[2:0])])
      else $error("specific end of interrupt ignored");
endmodule

// *** verification/cdic_host.sv ***
/*
 Host CPU model: byte I/O accesses and acknowledge pairs toward the block.
 Assumes inputs are driven on the falling edge of clk, sampled on the rising edge.
*/
`timescale 1ns/1ns
module cdic_host (
   // Clock
   input wire logic clk,
   // Requests to the block
   output cdic_pkg::cdic_io_type io_req,
   output logic interrupt_ack_cycle,
   // Answers from the block
   input wire logic [7:0] io_rdata,
   input wire logic io_rdata_oe,
   input wire logic [7:0] ack_vector,
   input wire logic ack_vector_oe,
   input wire logic [2:0] cascade_id
);
   // Idle bus at time zero
   initial begin
      io_req = '0;
      interrupt_ack_cycle = 1'b0;
   end

   // Byte write, strobe held for exactly one taking edge
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      io_req.addr = a;
      io_req.wdata = d;
      io_req.wr = 1'b1;
      @(negedge clk);
      io_req.wr = 1'b0;
      // Released bus shows no stale byte
      io_req.wdata = ~d;
   endtask

   // Byte read; answer is a one-cycle pulse, so sample it on the next falling edge
   task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic oe);
      @(negedge clk);
      io_req.addr = a;
      io_req.rd = 1'b1;
      @(negedge clk);
      io_req.rd = 1'b0;
      d = io_rdata;
      oe = io_rdata_oe;
   endtask

   // Two acknowledge cycles with one idle cycle between them
   task automatic ack_pair(output logic [2:0] cas, output logic first_oe,
                           output logic [7:0] vec, output logic vec_oe);
      @(negedge clk);
      interrupt_ack_cycle = 1'b1;
      @(negedge clk);
      interrupt_ack_cycle = 1'b0;
      cas = cascade_id;
      first_oe = ack_vector_oe;
      @(negedge clk);
      interrupt_ack_cycle = 1'b1;
      @(negedge clk);
      interrupt_ack_cycle = 1'b0;
      vec = ack_vector;
      vec_oe = ack_vector_oe;
   endtask
endmodule

// *** verification/tb_cdic.sv ***
/*
 Self-checking bench for the cascaded dual interrupt controller.
 Assumes cdic_top and the host model; pins change on the falling edge.
*/
`timescale 1ns/1ns
module tb_cdic;
   // Clock, reset and pins
   logic clk;
   logic resetn;
   logic [15:0] channel_irq;
   logic aux_irq;
   logic ser1_irq, ser1_gate_n, ser2_irq, ser2_gate_n;
   logic ser1_en, ser1_alt, ser2_en, ser2_alt;
   logic nmi_req;
   // Host model and block outputs
   cdic_pkg::cdic_io_type io_req;
   logic [7:0] io_rdata, ack_vector;
   logic io_rdata_oe, ack_vector_oe, ack_strobe, cpu_irq, nmi_out;
   logic [2:0] cascade_id;
   // Tallies
   int fails = 0;
   int check_count = 0;

   cdic_top cdic_top_i (.clk(clk), .resetn(resetn), .io_req(io_req), .io_rdata(io_rdata),
      .io_rdata_oe(io_rdata_oe), .interrupt_ack_cycle(ack_strobe),
      .cpu_interrupt_request(cpu_irq), .ack_vector(ack_vector),
      .ack_vector_oe(ack_vector_oe), .cascade_id(cascade_id), .channel_irq(channel_irq),
      .auxiliary_irq_input(aux_irq), .serial_one_irq_input(ser1_irq),
      .serial_one_irq_gate_n(ser1_gate_n), .serial_two_irq_input(ser2_irq),
      .serial_two_irq_gate_n(ser2_gate_n), .serial_one_enable(ser1_en),
      .serial_one_alternate(ser1_alt), .serial_two_enable(ser2_en),
      .serial_two_alternate(ser2_alt), .nmi_request(nmi_req), .nmi_to_cpu(nmi_out));

   cdic_host cdic_host_i (.clk(clk), .io_req(io_req), .interrupt_ack_cycle(ack_strobe),
      .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .ack_vector(ack_vector),
      .ack_vector_oe(ack_vector_oe), .cascade_id(cascade_id));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Single comparison point
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Read a port and compare the byte and its answer strobe
   task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic oe;
      cdic_host_i.io_read(a, d, oe);
      check({name, "_oe"}, 8'(oe), 8'h01);
      check(name, d, exp);
   endtask

   // Acknowledge pair with expected cascade identity and vector
   task automatic ack(input logic [2:0] exp_cas, input logic [7:0] exp_vec);
      logic [2:0] cas;
      logic first_oe, vec_oe;
      logic [7:0] vec;
      cdic_host_i.ack_pair(cas, first_oe, vec, vec_oe);
      check("first_ack_oe", 8'(first_oe), 8'h00);
      check("cascade_id", 8'(cas), 8'(exp_cas));
      check("vector_oe", 8'(vec_oe), 8'h01);
      check("vector", vec, exp_vec);
   endtask

   // Pin paths need three edges; allow four
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask

   // Span of all tests with ample margin
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report();
   end

   // Main sequence
   initial begin
      logic [7:0] d;
      logic oe;
      resetn = 1'b0;
      channel_irq = 16'h0000;
      {aux_irq, ser1_irq, ser1_gate_n, ser2_irq, ser2_gate_n} = 5'h00;
      {ser1_en, ser1_alt, ser2_en, ser2_alt, nmi_req} = 5'h00;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      check("irq_after_reset", 8'(cpu_irq), 8'h00);
      // Initialise both controllers; edge select left at zero is ignored
      cdic_host_i.io_write(16'h0020, 8'h11);
      cdic_host_i.io_write(16'h0021, 8'h08);
      cdic_host_i.io_write(16'h0021, 8'h04);
      cdic_host_i.io_write(16'h0021, 8'h01);
      cdic_host_i.io_write(16'h00A0, 8'h11);
      cdic_host_i.io_write(16'h00A1, 8'h70);
      cdic_host_i.io_write(16'h00A1, 8'h02);
      cdic_host_i.io_write(16'h00A1, 8'h01);
      cdic_host_i.io_write(16'h0021, 8'hFF);
      rd("master_mask", 16'h0021, 8'hFF);
      cdic_host_i.io_write(16'h00A1, 8'h5A);
      rd("slave_mask", 16'h00A1, 8'h5A);
      cdic_host_i.io_write(16'h0021, 8'h00);
      cdic_host_i.io_write(16'h00A1, 8'h00);
      // Unmapped port gives no answer
      cdic_host_i.io_read(16'h0022, d, oe);
      check("unmapped_oe", 8'(oe), 8'h00);
      // Two requests: level 3 must win over 5
      channel_irq = 16'h0028;
      settle();
      rd("master_pending", 16'h0020, 8'h28);
      check("irq_pending", 8'(cpu_irq), 8'h01);
      ack(3'h0, 8'h0B);
      cdic_host_i.io_write(16'h0020, 8'h0B);
      rd("master_in_service", 16'h0020, 8'h08);
      check("irq_blocked", 8'(cpu_irq), 8'h00);
      cdic_host_i.io_write(16'h0020, 8'h20);
      rd("in_service_after_eoi", 16'h0020, 8'h00);
      check("irq_level_held", 8'(cpu_irq), 8'h01);
      // Mask the higher line; the lower one is still serviced
      cdic_host_i.io_write(16'h0021, 8'h08);
      ack(3'h0, 8'h0D);
      cdic_host_i.io_write(16'h0020, 8'h20);
      cdic_host_i.io_write(16'h0021, 8'hFF);
      check("irq_all_masked", 8'(cpu_irq), 8'h00);
      cdic_host_i.io_write(16'h0021, 8'h00);
      cdic_host_i.io_write(16'h0020, 8'h0A);
      channel_irq = 16'h0400;
      settle();
      // Slave level 2 forwarded through master input 2
      rd("slave_pending", 16'h00A0, 8'h04);
      rd("master_cascade", 16'h0020, 8'h04);
      ack(3'h2, 8'h72);
      cdic_host_i.io_write(16'h0020, 8'h0B);
      rd("master_is_cascade", 16'h0020, 8'h04);
      cdic_host_i.io_write(16'h00A0, 8'h20);
      cdic_host_i.io_write(16'h0020, 8'h20);
      rd("master_is_cleared", 16'h0020, 8'h00);
      cdic_host_i.io_write(16'h0020, 8'h0A);
      channel_irq = 16'h0000;
      // Auxiliary and channel line share level 12
      aux_irq = 1'b1;
      settle();
      rd("aux_level", 16'h00A0, 8'h10);
      channel_irq = 16'h1000;
      aux_irq = 1'b0;
      settle();
      rd("shared_level", 16'h00A0, 8'h10);
      channel_irq = 16'h0000;
      settle();
      rd("shared_idle", 16'h00A0, 8'h00);
      // Poll read takes level 6 into service, a specific end clears it
      channel_irq = 16'h0040;
      settle();
      cdic_host_i.io_write(16'h0020, 8'h0C);
      rd("poll_byte", 16'h0020, 8'h86);
      cdic_host_i.io_write(16'h0020, 8'h0B);
      rd("poll_in_service", 16'h0020, 8'h40);
      cdic_host_i.io_write(16'h0020, 8'h66);
      rd("specific_eoi", 16'h0020, 8'h00);
      cdic_host_i.io_write(16'h0020, 8'h0A);
      channel_irq = 16'h0000;
      settle();
      // Nothing pending: level 7 vector of the base, nothing placed in service
      ack(3'h0, 8'h0F);
      // Serial routing: port, enable, address set and gate
      for (int i = 0; i < 16; i++) begin
         {ser2_irq, ser1_irq} = i[3] ? 2'b10 : 2'b01;
         {ser2_en, ser1_en} = i[2] ? (i[3] ? 2'b10 : 2'b01) : 2'b00;
         {ser2_alt, ser1_alt} = {i[1], i[1]};
         {ser2_gate_n, ser1_gate_n} = {i[0], i[0]};
         settle();
         rd("serial_route", 16'h0020,
            (!i[2] || i[0]) ? 8'h00 : (i[1] ? 8'h08 : 8'h10));
      end
      {ser1_irq, ser2_irq} = 2'b00;
      // Non-maskable request and its mask bit
      nmi_req = 1'b1;
      settle();
      check("nmi_open", 8'(nmi_out), 8'h01);
      cdic_host_i.io_write(16'h0070, 8'h80);
      settle();
      check("nmi_masked", 8'(nmi_out), 8'h00);
      cdic_host_i.io_write(16'h0070, 8'h00);
      settle();
      check("nmi_reopened", 8'(nmi_out), 8'h01);
      final_report();
   end
endmodule
